//--- ftc_ctrl.v
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "ftc_regs.vh"

// What this block does
// - Radio sync during a flash switches lamp from flash to torch current.
// - Coil overcurrent blocks the switch for the rest of the cycle, resumes next cycle.
// - Supply droop while flashing forces torch for the rest of that flash; the next flash start clears it.
// - Output overvoltage stops only the boost, restoring it when clear.
// - Undervoltage stops everything, latches its flag until enables cleared.
// - Overtemperature in latched mode stops everything and sets its flag.
// - Overtemperature in auto mode stops boost and source until it clears.
// - Low headroom with overvoltage stops everything, sets lamp-open flag.
// - Lamp pin low for 20 us stops everything, sets lamp-short flag.
// - Output at ground at once, or slow start for 1 ms, stops everything, sets flag.
// - Clearing both enables after a fault returns registers to reset.
// - Enable input clk_en gates every update; the power-on reset initialises the block.
// - Trigger-mode bit selects level control at 0, edge at 1.
// - Level mode lights while requested, cut at the programmed duration.
// - Torch bit drives torch current while it is one and no flash is lit.
// - Edge mode starts on a rising request, ends when duration expires.
// - A rising pin or a zero-to-one flash bit starts the timer.
// - Level mode: request fall resets the timer and cuts the lamp.
// - Pin and flash bit are ORed, independent of output voltage.
module ftc_ctrl #(
  parameter VOS_CYC  = `FTC_VOS_CYC,
  parameter STEP_CYC = `FTC_STEP_CYC_DEF
) (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire [31:0] prdata,
  output wire        pslverr,
  input  wire        flash_trigger_in,
  input  wire        radio_tx_sync_in,
  input  wire        boost_cycle_in,
  input  wire        coil_overcurrent_guard,
  input  wire        battery_low_cmp,
  input  wire        output_overvoltage_guard,
  input  wire        supply_under_cmp,
  input  wire        overtemp_cmp,
  input  wire        headroom_low_cmp,
  input  wire        lamp_low_cmp,
  input  wire        out_ground_cmp,
  input  wire        out_below_supply_cmp,
  output wire        boost_en,
  output wire        switch_allow,
  output wire        current_src_en,
  output wire        lamp_flash_mode,
  output wire        lamp_torch_mode,
  output wire [1:0]  current_limit_sel,
  output wire [1:0]  battery_threshold_sel
);

  // ========================================================================
  // Synchronised pin and comparator inputs.
  wire [11:0] sync_w;
  wire        trig_s;
  wire        tx_s;
  wire        cyc_s;
  wire        oc_s;
  wire        batt_s;
  wire        ovp_s;
  wire        uv_s;
  wire        ot_s;
  wire        head_s;
  wire        lamp_s;
  wire        gnd_s;
  wire        slow_s;

  ftc_sync #(
    .W (12)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .din     ({flash_trigger_in, radio_tx_sync_in, boost_cycle_in,
                coil_overcurrent_guard, battery_low_cmp,
                output_overvoltage_guard, supply_under_cmp, overtemp_cmp,
                headroom_low_cmp, lamp_low_cmp, out_ground_cmp,
                out_below_supply_cmp}),
    .dout    (sync_w)
  );

  assign trig_s = sync_w[11];
  assign tx_s   = sync_w[10];
  assign cyc_s  = sync_w[9];
  assign oc_s   = sync_w[8];
  assign batt_s = sync_w[7];
  assign ovp_s  = sync_w[6];
  assign uv_s   = sync_w[5];
  assign ot_s   = sync_w[4];
  assign head_s = sync_w[3];
  assign lamp_s = sync_w[2];
  assign gnd_s  = sync_w[1];
  assign slow_s = sync_w[0];

  // ========================================================================
  // Registers and state.
  reg [`FTC_CTRL_W-1:0] ctrl_ff;
  reg [`FTC_CFG_W-1:0]  cfg_ff;
  reg [`FTC_ST_W-1:0]   status_ff;
  reg [31:0]            rdata_ff;
  reg                   rerr_ff;
  reg                   trig_d_ff;
  reg                   cyc_d_ff;
  reg                   flash_act_ff;
  reg                   droop_ff;
  reg                   sw_gate_ff;
  reg                   startup_ff;
  reg [3:0]             slot_ff;
  reg [23:0]            step_ff;
  reg [11:0]            ls_cnt_ff;
  reg [23:0]            vos_cnt_ff;
  reg                   boost_ff;
  reg                   src_ff;
  reg                   flash_ff;
  reg                   torch_ff;

  wire [2:0] idx     = paddr[4:2];
  wire       hit     = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'b00);
  wire       setup   = psel && !penable;
  wire       wr_acc  = psel && penable && pwrite && clk_en;
  wire       en_any  = ctrl_ff[`FTC_CTRL_EN_A] | ctrl_ff[`FTC_CTRL_EN_B];
  wire       edge_md = ctrl_ff[`FTC_CTRL_EDGE];
  wire       tmode   = ctrl_ff[`FTC_CTRL_TMODE];
  wire       flash_b = ctrl_ff[`FTC_CTRL_FLASH];
  wire       torch_b = ctrl_ff[`FTC_CTRL_TORCH];
  wire [3:0] dur     = cfg_ff[`FTC_CFG_TIME_MSB:`FTC_CFG_TIME_LSB];
  wire       latched = |status_ff;

  // ========================================================================
  // Bus write decode.
  reg                   wr_ctrl;
  reg                   wr_cfg;
  reg                   recover;
  reg [`FTC_CTRL_W-1:0] nxt_ctrl;

  always @*
  begin
    wr_ctrl = 1'b0;
    wr_cfg  = 1'b0;
    if (wr_acc && hit && (idx == `FTC_IDX_CTRL))
      wr_ctrl = 1'b1;
    else if (wr_acc && hit && (idx == `FTC_IDX_CFG))
      wr_cfg = 1'b1;
    recover  = wr_ctrl && latched && (pwdata[1:0] == 2'b00);
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl)
      nxt_ctrl = pwdata[`FTC_CTRL_W-1:0];
  end

  // ========================================================================
  // Flash request and timer.
  // pin and bit form one request
  wire req      = trig_s | flash_b;
  wire rise_pin = trig_s & ~trig_d_ff;
  wire rise_bit = wr_ctrl & pwdata[`FTC_CTRL_FLASH] & ~flash_b;
  wire fall_bit = wr_ctrl & ~pwdata[`FTC_CTRL_FLASH] & flash_b;
  wire fall_pin = ~trig_s & trig_d_ff;
  // timer start on either rising source
  wire start    = (rise_pin | rise_bit) & en_any & ~latched;
  wire expire   = flash_act_ff && (slot_ff == dur) &&
                  (step_ff == STEP_CYC[23:0] - 24'h000001);
  wire lvl_stop = !edge_md && ((fall_pin && !flash_b) ||
                  (fall_bit && !trig_s) || !req);

  reg        nxt_act;
  reg [3:0]  nxt_slot;
  reg [23:0] nxt_step;

  always @*
  begin
    nxt_act  = flash_act_ff;
    nxt_slot = slot_ff;
    nxt_step = step_ff;
    if (start)
    begin
      nxt_act  = 1'b1;
      nxt_slot = 4'h0;
      nxt_step = 24'h000000;
    end
    // level mode stops at the programmed duration
    // edge mode ends on expiry, on cleared enables or on a latched fault
    else if (expire || lvl_stop || !en_any || latched)
    begin
      nxt_act  = 1'b0;
      nxt_slot = 4'h0;
      nxt_step = 24'h000000;
    end
    else if (flash_act_ff)
    begin
      if (step_ff == STEP_CYC[23:0] - 24'h000001)
      begin
        nxt_step = 24'h000000;
        nxt_slot = slot_ff + 4'h1;
      end
      else
        nxt_step = step_ff + 24'h000001;
    end
  end

  // ========================================================================
  // Protection detection.
  wire ot_latch  = ot_s & ~tmode;
  wire ot_auto   = ot_s & tmode;
  wire ls_hit    = ls_cnt_ff == `FTC_LS_CYC - 1;
  wire vos_hit   = vos_cnt_ff == VOS_CYC[23:0] - 24'h000001;
  wire en_rise   = wr_ctrl && !en_any && (pwdata[1:0] != 2'b00);

  reg [`FTC_ST_W-1:0] ev;

  always @*
  begin
    ev = {`FTC_ST_W{1'b0}};
    if (en_any)
    begin
      ev[`FTC_ST_SUPPLY_LOW] = uv_s;
      ev[`FTC_ST_OVERTEMP]   = ot_latch;
      ev[`FTC_ST_LAMP_OPEN]  = head_s & ovp_s;
      ev[`FTC_ST_LAMP_SHORT] = lamp_s & ls_hit;
      ev[`FTC_ST_OUT_SHORT]  = gnd_s | (startup_ff & slow_s & vos_hit);
    end
  end

  // ========================================================================
  // Lamp and power outputs.
  // overvoltage drops only the boost
  // auto thermal drops boost and source
  wire run      = en_any & ~latched & ~(|ev);
  wire nxt_bst  = run & ~ovp_s & ~ot_auto;
  // radio sync moves flash to torch
  wire fl_torch = flash_act_ff & (tx_s | droop_ff | batt_s);
  wire nxt_fl   = run & ~ot_auto & flash_act_ff & ~tx_s & ~droop_ff & ~batt_s;
  wire nxt_to   = run & ~ot_auto & ~nxt_fl & (torch_b | fl_torch);

  // ========================================================================
  // Clocked state.
  // power-on reset initialises everything
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrl_ff      <= `FTC_CTRL_RST;
      cfg_ff       <= `FTC_CFG_RST;
      status_ff    <= `FTC_ST_RST;
      rdata_ff     <= 32'h00000000;
      rerr_ff      <= 1'b0;
      trig_d_ff    <= 1'b0;
      cyc_d_ff     <= 1'b0;
      flash_act_ff <= 1'b0;
      droop_ff     <= 1'b0;
      sw_gate_ff   <= 1'b1;
      startup_ff   <= 1'b0;
      slot_ff      <= 4'h0;
      step_ff      <= 24'h000000;
      ls_cnt_ff    <= 12'h000;
      vos_cnt_ff   <= 24'h000000;
      boost_ff     <= 1'b0;
      src_ff       <= 1'b0;
      flash_ff     <= 1'b0;
      torch_ff     <= 1'b0;
    end
    else if (clk_en)
    begin
      trig_d_ff <= trig_s;
      cyc_d_ff  <= cyc_s;
      // recovery returns registers to reset; new events still set
      if (recover)
      begin
        ctrl_ff   <= `FTC_CTRL_RST;
        cfg_ff    <= `FTC_CFG_RST;
        status_ff <= ev;
      end
      else
      begin
        ctrl_ff   <= nxt_ctrl;
        status_ff <= status_ff | ev;
        if (wr_cfg)
          cfg_ff <= pwdata[`FTC_CFG_W-1:0];
      end
      // edge bit selects the trigger style inside the timer logic
      flash_act_ff <= nxt_act;
      slot_ff      <= nxt_slot;
      step_ff      <= nxt_step;
      // droop holds until the next flash start
      if (start)
        droop_ff <= 1'b0;
      else if (flash_act_ff && batt_s)
        droop_ff <= 1'b1;
      // switch blocked for the rest of the cycle
      if (oc_s)
        sw_gate_ff <= 1'b0;
      else if (cyc_s && !cyc_d_ff)
        sw_gate_ff <= 1'b1;
      if (lamp_s && en_any && !ls_hit)
        ls_cnt_ff <= ls_cnt_ff + 12'h001;
      else if (!lamp_s)
        ls_cnt_ff <= 12'h000;
      if (en_rise)
        startup_ff <= 1'b1;
      else if (!slow_s || !en_any)
        startup_ff <= 1'b0;
      if (startup_ff && slow_s && !vos_hit)
        vos_cnt_ff <= vos_cnt_ff + 24'h000001;
      else if (!startup_ff)
        vos_cnt_ff <= 24'h000000;
      boost_ff <= nxt_bst;
      src_ff   <= nxt_fl | nxt_to;
      flash_ff <= nxt_fl;
      torch_ff <= nxt_to;
      // Read data is captured in the setup phase.
      if (setup)
      begin
        rdata_ff <= 32'h00000000;
        rerr_ff  <= 1'b0;
        if (!hit)
          rerr_ff <= 1'b1;
        else if (idx == `FTC_IDX_CTRL)
          rdata_ff <= {26'h0, ctrl_ff};
        else if (idx == `FTC_IDX_CFG)
          rdata_ff <= {24'h0, cfg_ff};
        else if (idx == `FTC_IDX_STATUS)
          rdata_ff <= {27'h0, status_ff};
        else if (idx == `FTC_IDX_STATE)
          rdata_ff <= {25'h0, startup_ff, sw_gate_ff, ot_auto, ovp_s,
                       tx_s, droop_ff, flash_act_ff};
        else
          rerr_ff <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Port drive.
  assign pready                = clk_en;
  assign prdata                = rdata_ff;
  assign pslverr               = rerr_ff & psel & penable;
  assign boost_en              = boost_ff;
  assign switch_allow          = boost_ff & sw_gate_ff;
  assign current_src_en        = src_ff;
  assign lamp_flash_mode       = flash_ff;
  assign lamp_torch_mode       = torch_ff;
  assign current_limit_sel     = cfg_ff[`FTC_CFG_LIM_MSB:`FTC_CFG_LIM_LSB];
  assign battery_threshold_sel = cfg_ff[`FTC_CFG_BATT_MSB:`FTC_CFG_BATT_LSB];

endmodule // ftc_ctrl

//--- ftc_ctrl_props.sv
`timescale 1ns/1ps

// ==========
// Port checks of the lamp control block.
module ftc_ctrl_props #(
  parameter STEP_CYC = 10
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic flash_trigger_in,
  input wire logic radio_tx_sync_in,
  input wire logic coil_overcurrent_guard,
  input wire logic output_overvoltage_guard,
  input wire logic supply_under_cmp,
  input wire logic overtemp_cmp,
  input wire logic lamp_low_cmp,
  input wire logic out_ground_cmp,
  input wire logic boost_en,
  input wire logic switch_allow,
  input wire logic current_src_en,
  input wire logic lamp_flash_mode,
  input wire logic lamp_torch_mode
);
  localparam int FMAX = 16 * STEP_CYC + 8;
  logic [31:0] fcnt_ff;
  logic [12:0] lcnt_ff;
  logic        trg_ff;

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Flash length restarts on any new request; lamp-low time is counted.
  always @(posedge mclk)
  begin
    trg_ff <= flash_trigger_in;
    if (!lamp_flash_mode || (flash_trigger_in && !trg_ff) || (psel && penable && pwrite))
      fcnt_ff <= 32'h00000000;
    else
      fcnt_ff <= fcnt_ff + 32'h00000001;
    if (!lamp_low_cmp)
      lcnt_ff <= 13'h0000;
    else if (lcnt_ff != 13'h1fff)
      lcnt_ff <= lcnt_ff + 13'h0001;
  end

  property p_rst;
    $fell(sys_rst) |-> !(boost_en || switch_allow || current_src_en || lamp_flash_mode
      || lamp_torch_mode);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_radio;
    radio_tx_sync_in [*4] |-> !lamp_flash_mode;
  endproperty
  a_radio: assert property (p_radio) else $error("flash kept under radio sync");
  property p_oc;
    coil_overcurrent_guard [*4] |-> !switch_allow;
  endproperty
  a_oc: assert property (p_oc) else $error("switch allowed in overcurrent");
  property p_ovp;
    output_overvoltage_guard [*4] |-> !boost_en;
  endproperty
  a_ovp: assert property (p_ovp) else $error("boost on in overvoltage");
  property p_uv;
    supply_under_cmp [*4] |-> !(boost_en || current_src_en);
  endproperty
  a_uv: assert property (p_uv) else $error("power on in undervoltage");
  property p_ot;
    overtemp_cmp [*4] |-> !(boost_en || current_src_en);
  endproperty
  a_ot: assert property (p_ot) else $error("power on when hot");
  property p_short;
    out_ground_cmp [*4] |-> !boost_en;
  endproperty
  a_short: assert property (p_short) else $error("boost on with output shorted");
  property p_lamp;
    lcnt_ff == 13'd4010 |-> !(boost_en || current_src_en);
  endproperty
  a_lamp: assert property (p_lamp) else $error("power on with lamp shorted");
  property p_fdur;
    fcnt_ff <= FMAX;
  endproperty
  a_fdur: assert property (p_fdur) else $error("flash too long");
endmodule // ftc_ctrl_props

bind ftc_ctrl ftc_ctrl_props #(.STEP_CYC(STEP_CYC)) ftc_ctrl_props_i (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .flash_trigger_in(flash_trigger_in), .radio_tx_sync_in(radio_tx_sync_in),
  .coil_overcurrent_guard(coil_overcurrent_guard),
  .output_overvoltage_guard(output_overvoltage_guard),
  .supply_under_cmp(supply_under_cmp), .overtemp_cmp(overtemp_cmp),
  .lamp_low_cmp(lamp_low_cmp), .out_ground_cmp(out_ground_cmp), .boost_en(boost_en),
  .switch_allow(switch_allow), .current_src_en(current_src_en),
  .lamp_flash_mode(lamp_flash_mode), .lamp_torch_mode(lamp_torch_mode));

//--- ftc_power_model.sv
`timescale 1ns/1ps

// ==========
// Switching-cycle source; it stands still while the boost is off.
module ftc_power_model (
  input  wire logic mclk,
  input  wire logic boost_en,
  output wire logic boost_cycle_in
);
  logic [1:0] div_ff = 2'h0;

  always @(posedge mclk)
  begin
    div_ff <= boost_en ? div_ff + 2'h1 : 2'h0;
  end

  assign boost_cycle_in = div_ff[1];
endmodule // ftc_power_model

//--- ftc_regs.vh
`ifndef FTC_REGS_VH
`define FTC_REGS_VH

// ==========================================================================
// Clock and timing.
`define FTC_CLK_PERIOD_NS  5
`define FTC_LS_TIME_US     20
`define FTC_LS_CYC         ((`FTC_LS_TIME_US * 1000) / `FTC_CLK_PERIOD_NS)
`define FTC_VOS_TIME_MS    1
`define FTC_VOS_CYC        ((`FTC_VOS_TIME_MS * 1000000) / `FTC_CLK_PERIOD_NS)
`define FTC_STEP_CYC_DEF   10000000

// ==========================================================================
// Register indices; the byte address is four times the index.
`define FTC_IDX_CTRL    3'h0
`define FTC_IDX_CFG     3'h1
`define FTC_IDX_STATUS  3'h6
`define FTC_IDX_STATE   3'h7

// ==========================================================================
// Control register fields.
`define FTC_CTRL_EN_A    0
`define FTC_CTRL_EN_B    1
`define FTC_CTRL_TORCH   2
`define FTC_CTRL_FLASH   3
`define FTC_CTRL_EDGE    4
`define FTC_CTRL_TMODE   5
`define FTC_CTRL_W       6
`define FTC_CTRL_RST     6'h00

// ==========================================================================
// Configuration register fields.
`define FTC_CFG_TIME_LSB  0
`define FTC_CFG_TIME_MSB  3
`define FTC_CFG_BATT_LSB  4
`define FTC_CFG_BATT_MSB  5
`define FTC_CFG_LIM_LSB   6
`define FTC_CFG_LIM_MSB   7
`define FTC_CFG_W         8
`define FTC_CFG_RST       8'h00

// ==========================================================================
// Status register fields.
`define FTC_ST_SUPPLY_LOW  0
`define FTC_ST_OVERTEMP    1
`define FTC_ST_LAMP_OPEN   2
`define FTC_ST_LAMP_SHORT  3
`define FTC_ST_OUT_SHORT   4
`define FTC_ST_W           5
`define FTC_ST_RST         5'h00

`endif

//--- ftc_sync.v
`timescale 1ns/1ps

// ==========================================================================
// Two-stage synchroniser, one pair of flip-flops per bit.
module ftc_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         sys_rst,
  input  wire         clk_en,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  genvar i;

  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg meta_ff;
      reg sync_ff;
      always @(posedge mclk)
      begin
        if (sys_rst)
        begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end
        else if (clk_en)
        begin
          meta_ff <= din[i];
          sync_ff <= meta_ff;
        end
      end
      assign dout[i] = sync_ff;
    end
  endgenerate

endmodule // ftc_sync

//--- tb.sv
`timescale 1ns/1ps
`include "ftc_regs.vh"

module tb;
  localparam int STEP = 10;
  localparam int SETTLE = 20;
  localparam logic [7:0] A_CTRL = {3'h0, `FTC_IDX_CTRL, 2'h0};
  localparam logic [7:0] A_CFG  = {3'h0, `FTC_IDX_CFG, 2'h0};
  localparam logic [7:0] A_ST   = {3'h0, `FTC_IDX_STATUS, 2'h0};
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        trig = 1'b0;
  logic [9:0]  cmp = 10'h000;
  wire         pready, pslverr, bcyc, boost_en, switch_allow;
  wire         current_src_en, lamp_flash_mode, lamp_torch_mode;
  wire  [31:0] prdata;
  wire  [1:0]  lim, bsel;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [31:0] rd;
  logic        err;
  logic [9:0]  fc [8] = '{10'h001, 10'h002, 10'h002, 10'h044, 10'h040, 10'h008,
                          10'h010, 10'h020};
  logic [7:0]  fctl [8] = '{8'h01, 8'h01, 8'h21, 8'h01, 8'h03, 8'h01, 8'h02, 8'h01};
  int          fh [8] = '{8, 8, 8, 8, 8, 4020, 8, 40};
  logic [31:0] fst [8] = '{1, 2, 0, 4, 0, 8, 16, 16};

  ftc_ctrl #(.VOS_CYC(20), .STEP_CYC(STEP)) ftc_ctrl_i (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .flash_trigger_in(trig), .radio_tx_sync_in(cmp[8]),
    .boost_cycle_in(bcyc), .coil_overcurrent_guard(cmp[9]), .battery_low_cmp(cmp[7]),
    .output_overvoltage_guard(cmp[6]), .supply_under_cmp(cmp[0]), .overtemp_cmp(cmp[1]),
    .headroom_low_cmp(cmp[2]), .lamp_low_cmp(cmp[3]), .out_ground_cmp(cmp[4]),
    .out_below_supply_cmp(cmp[5]), .boost_en(boost_en), .switch_allow(switch_allow),
    .current_src_en(current_src_en), .lamp_flash_mode(lamp_flash_mode),
    .lamp_torch_mode(lamp_torch_mode), .current_limit_sel(lim),
    .battery_threshold_sel(bsel));

  ftc_power_model ftc_power_model_i (.mclk(mclk), .boost_en(boost_en),
    .boost_cycle_in(bcyc));

  always #2.5 mclk = ~mclk;

  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk(err, ee);
  endtask

  initial
  begin
    wt(6);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rdchk(A_CTRL, 0, 0);
    rdchk(A_CFG, 0, 0);
    rdchk(A_ST, 0, 0);
    rdchk(8'h1c, 32'h20, 0);
    rdchk(8'h08, 0, 1);
    apb(1'b1, A_CFG, 32'he1);
    wt(2);
    chk(lim, 3);
    chk(bsel, 2);
    wt(SETTLE);
    apb(1'b1, A_CTRL, 32'h05);
    wt(2);
    chk(lamp_torch_mode, 1);
    chk(current_src_en, 1);
    ce <= 1'b0;
    wt(4);
    chk(pready, 0);
    chk(lamp_torch_mode, 1);
    ce <= 1'b1;
    wt(1);
    apb(1'b1, A_CTRL, 32'h01);
    wt(2);
    chk(lamp_torch_mode, 0);
    chk(current_src_en, 0);
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, A_CTRL, 32'h01 | (m << 4));
      wt(SETTLE);
      trig <= 1'b1;
      wt(5);
      chk(lamp_flash_mode, 1);
      trig <= 1'b0;
      wt(5);
      chk(lamp_flash_mode, m);
      wt(30);
      trig <= 1'b1;
      wt(5);
      chk(lamp_flash_mode, 1);
      wt(30);
      chk(lamp_flash_mode, 0);
      trig <= 1'b0;
      wt(5);
    end
    apb(1'b1, A_CTRL, 32'h09);
    wt(2);
    chk(lamp_flash_mode, 1);
    apb(1'b1, A_CTRL, 32'h01);
    wt(2);
    chk(lamp_flash_mode, 0);
    for (int i = 0; i < 2; i++)
    begin
      trig <= 1'b1;
      wt(5);
      cmp[8 - i] <= 1'b1;
      wt(5);
      chk({lamp_flash_mode, lamp_torch_mode}, 1);
      cmp <= 10'h000;
      wt(5);
      chk(lamp_flash_mode, i == 0);
      trig <= 1'b0;
      wt(30);
    end
    trig <= 1'b1;
    wt(5);
    chk(lamp_flash_mode, 1);
    trig <= 1'b0;
    wt(10);
    cmp[9] <= 1'b1;
    wt(5);
    chk(switch_allow, 0);
    cmp[9] <= 1'b0;
    wt(20);
    chk(switch_allow, 1);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, A_CTRL, 32'h0);
      apb(1'b1, A_CFG, 32'he1);
      cmp <= fc[i];
      apb(1'b1, A_CTRL, {24'h0, fctl[i]});
      wt(fh[i]);
      chk(boost_en, 0);
      rdchk(A_ST, fst[i], 0);
      cmp <= 10'h000;
      wt(8);
      chk(boost_en, fst[i] == 0);
      if (fst[i] != 0)
      begin
        apb(1'b1, A_CTRL, 32'h0);
        rdchk(A_CFG, 0, 0);
        rdchk(A_ST, 0, 0);
      end
    end
    end_of_test();
  end
endmodule // tb
